// file: inc/sbi_params.svh
// Constants for the skip, branch and increment execution block
// Functional notes
// - Decrement-skip: subtract one, flags unchanged
// - Destination bit zero accumulator, one file
// - Zero decrement result discards fetched instruction
// - Jump loads eleven-bit immediate into pc
// - Jump pc upper bits from latch 4:3
// - Jump always takes two cycles
// - Increment modulo 256, sets zero flag
`ifndef SBI_PARAMS_SVH
`define SBI_PARAMS_SVH

// Instruction word layout
`define SBI_INSTR_WIDTH      14
`define SBI_OPCODE_MSB       13
`define SBI_OPCODE_LSB       8
`define SBI_DEST_BIT         7
`define SBI_FADDR_MSB        6
`define SBI_FADDR_WIDTH      7
`define SBI_JUMP_CLASS_LSB   11
`define SBI_JUMP_IMM_MSB     10
`define SBI_JUMP_IMM_WIDTH   11

// Opcode patterns
`define SBI_OP_DEC_SKIP      6'h0B
`define SBI_OP_INCREMENT     6'h0A
`define SBI_OP_JUMP          3'h5

// Data path and program counter
`define SBI_DATA_WIDTH       8
`define SBI_PC_WIDTH         13
`define SBI_PAGE_HI_BIT      4
`define SBI_PAGE_LO_BIT      3

// Reset values
`define SBI_PC_RESET         13'h0000
`define SBI_ACC_RESET        8'h00
`define SBI_ZERO_RESET       1'h0

`endif

// file: inc/sbi_pkg.sv
// Types for the skip, branch and increment execution block
`include "sbi_params.svh"

package sbi_pkg;

  typedef enum logic [1:0] {
    SBI_ST_EXEC = 2'h1,
    SBI_ST_NOP  = 2'h2
  } sbi_state_type;

  typedef enum logic [1:0] {
    SBI_OP_OTHER    = 2'h0,
    SBI_OP_DEC_SKIP = 2'h1,
    SBI_OP_INC      = 2'h2,
    SBI_OP_JUMP     = 2'h3
  } sbi_opclass_type;

endpackage : sbi_pkg

// file: hw/sbi_decode.sv
// Instruction decoder and increment/decrement data path
`timescale 1ns/10ps
`default_nettype none
`include "sbi_params.svh"

module sbi_decode
  import sbi_pkg::*;
(
  input  wire logic [`SBI_INSTR_WIDTH-1:0]    instr,
  input  wire logic [`SBI_DATA_WIDTH-1:0]     operand,
  input  wire logic [`SBI_DATA_WIDTH-1:0]     page_high_latch,
  output sbi_opclass_type                     opclass,
  output logic      [`SBI_FADDR_WIDTH-1:0]    file_addr,
  output logic                                dest_file,
  output logic      [`SBI_DATA_WIDTH-1:0]     result,
  output logic                                result_zero,
  output logic      [`SBI_PC_WIDTH-1:0]       jump_target
);

  logic [`SBI_OPCODE_MSB-`SBI_OPCODE_LSB:0] opcode;

  assign opcode = instr[`SBI_OPCODE_MSB:`SBI_OPCODE_LSB];

  always_comb begin
    if (instr[`SBI_OPCODE_MSB:`SBI_JUMP_CLASS_LSB] == `SBI_OP_JUMP) begin
      opclass = SBI_OP_JUMP;
    end else if (opcode == `SBI_OP_DEC_SKIP) begin
      opclass = SBI_OP_DEC_SKIP;
    end else if (opcode == `SBI_OP_INCREMENT) begin
      opclass = SBI_OP_INC;
    end else begin
      opclass = SBI_OP_OTHER;
    end
  end

  assign file_addr = instr[`SBI_FADDR_MSB:0];
  assign dest_file = instr[`SBI_DEST_BIT];

  always_comb begin
    if (opclass == SBI_OP_DEC_SKIP) begin
      result = operand - `SBI_DATA_WIDTH'(1);
    end else begin
      result = operand + `SBI_DATA_WIDTH'(1);
    end
  end

  assign result_zero = (result == '0);

  assign jump_target = {page_high_latch[`SBI_PAGE_HI_BIT:`SBI_PAGE_LO_BIT],
                        instr[`SBI_JUMP_IMM_MSB:0]};

endmodule : sbi_decode

`default_nettype wire

// file: hw/sbi_exec.sv
// Execution unit for decrement-skip, unconditional jump and increment
`timescale 1ns/10ps
`default_nettype none
`include "sbi_params.svh"

module sbi_exec
  import sbi_pkg::*;
#(
  parameter int DATA_WIDTH = `SBI_DATA_WIDTH,
  parameter int PC_WIDTH   = `SBI_PC_WIDTH
)
(
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [`SBI_INSTR_WIDTH-1:0]    instr,
  input  wire logic                           instr_valid,
  input  wire logic [DATA_WIDTH-1:0]          operand,
  input  wire logic [DATA_WIDTH-1:0]          page_high_latch,
  output logic                                ready,
  output logic                                no_operation_cycle,
  output logic      [PC_WIDTH-1:0]            pc,
  output logic      [DATA_WIDTH-1:0]          accumulator,
  output logic                                zero_flag,
  output logic                                file_wr_en,
  output logic      [`SBI_FADDR_WIDTH-1:0]    file_wr_addr,
  output logic      [DATA_WIDTH-1:0]          file_wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  sbi_opclass_type                opclass;
  logic [`SBI_FADDR_WIDTH-1:0]    dec_file_addr;
  logic                           dec_dest_file;
  logic [`SBI_DATA_WIDTH-1:0]     dec_result;
  logic                           dec_result_zero;
  logic [`SBI_PC_WIDTH-1:0]       dec_jump_target;

  sbi_decode u_decode (
    .instr           (instr),
    .operand         (operand),
    .page_high_latch (page_high_latch),
    .opclass         (opclass),
    .file_addr       (dec_file_addr),
    .dest_file       (dec_dest_file),
    .result          (dec_result),
    .result_zero     (dec_result_zero),
    .jump_target     (dec_jump_target)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and instruction classes

  sbi_state_type state;
  sbi_state_type next_state;
  logic          accept;
  logic          is_dec_skip;
  logic          is_inc;
  logic          is_jump;
  logic          is_arith;
  logic          take_skip;
  logic          need_nop;

  // Instructions are taken only in the execute state
  assign accept      = instr_valid && (state == SBI_ST_EXEC);
  assign is_dec_skip = accept && (opclass == SBI_OP_DEC_SKIP);
  assign is_inc      = accept && (opclass == SBI_OP_INC);
  assign is_jump     = accept && (opclass == SBI_OP_JUMP);
  assign is_arith    = is_dec_skip || is_inc;

  assign take_skip = is_dec_skip && dec_result_zero;

  assign need_nop = take_skip || is_jump;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  always_comb begin
    case (state)
      SBI_ST_EXEC: begin
        if (need_nop) begin
          next_state = SBI_ST_NOP;
        end else begin
          next_state = SBI_ST_EXEC;
        end
      end
      // The word fetched behind the skip or jump is dropped here
      SBI_ST_NOP: begin
        next_state = SBI_ST_EXEC;
      end
      default: begin
        next_state = SBI_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SBI_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // Ready mirrors the state so it comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready <= 1'b1;
    end else begin
      ready <= (next_state == SBI_ST_EXEC);
    end
  end

  // discard pulse during the extra cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      no_operation_cycle <= 1'b0;
    end else begin
      no_operation_cycle <= need_nop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter: address of the next instruction to execute

  logic [PC_WIDTH-1:0] next_pc;

  always_comb begin
    if (is_jump) begin
      next_pc = PC_WIDTH'(dec_jump_target);
    end else if (take_skip) begin
      next_pc = pc + PC_WIDTH'(2);
    end else if (accept) begin
      next_pc = pc + PC_WIDTH'(1);
    end else begin
      next_pc = pc;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= `SBI_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result routing

  logic [DATA_WIDTH-1:0] next_accumulator;

  always_comb begin
    if (is_arith && !dec_dest_file) begin
      next_accumulator = DATA_WIDTH'(dec_result);
    end else begin
      next_accumulator = accumulator;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accumulator <= `SBI_ACC_RESET;
    end else begin
      accumulator <= next_accumulator;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_wr_en <= 1'b0;
    end else begin
      file_wr_en <= is_arith && dec_dest_file;
    end
  end

  // write address from low seven bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_wr_addr <= '0;
    end else if (is_arith && dec_dest_file) begin
      file_wr_addr <= dec_file_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_wr_data <= '0;
    end else if (is_arith && dec_dest_file) begin
      file_wr_data <= DATA_WIDTH'(dec_result);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status

  logic next_zero_flag;

  always_comb begin
    if (is_inc) begin
      next_zero_flag = dec_result_zero;
    end else begin
      next_zero_flag = zero_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zero_flag <= `SBI_ZERO_RESET;
    end else begin
      zero_flag <= next_zero_flag;
    end
  end

endmodule : sbi_exec

`default_nettype wire

// file: verification/sbi_exec_assertions.sv
// Assertion checker for the skip, branch and increment block
`timescale 1ns/10ps
`default_nettype none
`include "sbi_params.svh"
module sbi_exec_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [13:0] instr,
  input wire logic        instr_valid,
  input wire logic [7:0]  operand,
  input wire logic [7:0]  page_high_latch,
  input wire logic        ready,
  input wire logic        no_operation_cycle,
  input wire logic [12:0] pc,
  input wire logic [7:0]  accumulator,
  input wire logic        zero_flag,
  input wire logic        file_wr_en,
  input wire logic [6:0]  file_wr_addr,
  input wire logic [7:0]  file_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic dec;
  logic inc;
  logic jmp;
  assign tk  = instr_valid & ready;
  assign dec = tk & (instr[13:8] == `SBI_OP_DEC_SKIP);
  assign inc = tk & (instr[13:8] == `SBI_OP_INCREMENT);
  assign jmp = tk & (instr[13:11] == `SBI_OP_JUMP);
  a_dec_file_write: assert property (dec && instr[7] |=> file_wr_en && file_wr_addr == $past(instr[6:0])
    && file_wr_data == $past(operand) - 8'h01) else $error("decrement write wrong");
  a_dec_flag_hold: assert property (dec |=> $stable(zero_flag)) else $error("decrement moved zero flag");
  a_dest_accum: assert property ((dec || inc) && !instr[7] |=> !file_wr_en
    && accumulator == $past(operand) + ($past(dec) ? 8'hFF : 8'h01)) else $error("accumulator result wrong");
  a_skip_discard: assert property (dec && operand == 8'h01 |=> no_operation_cycle && !ready
    ##1 ready && !no_operation_cycle) else $error("skip cycle wrong");
  a_no_skip: assert property (dec && operand != 8'h01 |=> ready && !no_operation_cycle) else $error("bad skip");
  a_jump_target: assert property (jmp |=> pc == {$past(page_high_latch[4:3]), $past(instr[10:0])})
    else $error("jump target wrong");
  a_jump_two: assert property (jmp |=> !ready ##1 ready) else $error("jump not two cycles");
  a_inc_zero: assert property (inc |=> ready && zero_flag == ($past(operand) == 8'hFF))
    else $error("increment zero flag wrong");
  a_inc_file_write: assert property (inc && instr[7] |=> file_wr_en && file_wr_addr == $past(instr[6:0])
    && file_wr_data == $past(operand) + 8'h01) else $error("increment write wrong");
endmodule : sbi_exec_checker
bind sbi_exec sbi_exec_checker u_chk (.clk, .sys_rst, .instr, .instr_valid, .operand, .page_high_latch, .ready,
  .no_operation_cycle, .pc, .accumulator, .zero_flag, .file_wr_en, .file_wr_addr, .file_wr_data);
`default_nettype wire

// file: verification/tb_skip_branch_increment_exec.sv
// Self-checking testbench for the skip, branch and increment block
`timescale 1ns/10ps
`default_nettype none
`include "sbi_params.svh"
module tb_skip_branch_increment_exec;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        instr_valid = 0;
  logic [13:0] instr = 0;
  logic [7:0]  operand = 0;
  logic [7:0]  page_high_latch = 0;
  logic        ready, no_operation_cycle, zero_flag, file_wr_en;
  logic [12:0] pc, e_pc;
  logic [7:0]  accumulator, file_wr_data, e_acc, r;
  logic [6:0]  file_wr_addr;
  logic        e_z, dead;
  int          err_count = 0, tests_run = 0, cycles = 0, seed = 72859;

  sbi_exec uut (.clk, .sys_rst, .instr, .instr_valid, .operand, .page_high_latch, .ready,
    .no_operation_cycle, .pc, .accumulator, .zero_flag, .file_wr_en, .file_wr_addr, .file_wr_data);

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Presents one word at a falling edge and checks the outcome one cycle later
  task automatic run(input logic [13:0] w, input logic [7:0] op);
    logic [5:0] o;
    logic       wr;
    o = w[13:8];
    wr = 0;
    dead = 0;
    instr = w;
    operand = op;
    instr_valid = 1;
    page_high_latch = 8'($random(seed));
    e_pc = e_pc + 13'h0001;
    if (w[13:11] == `SBI_OP_JUMP) begin
      e_pc = {page_high_latch[4:3], w[10:0]};
      dead = 1;
    end else if (o == `SBI_OP_DEC_SKIP || o == `SBI_OP_INCREMENT) begin
      r = (o == `SBI_OP_INCREMENT) ? op + 8'h01 : op - 8'h01;
      if (o == `SBI_OP_INCREMENT) e_z = (r == 8'h00);
      else if (r == 8'h00) begin
        e_pc = e_pc + 13'h0001;
        dead = 1;
      end
      if (w[7]) wr = 1;
      else e_acc = r;
    end
    @(negedge clk);
    chk(pc, e_pc);
    chk(accumulator, e_acc);
    chk(zero_flag, e_z);
    chk(file_wr_en, wr);
    if (wr) chk({file_wr_addr, file_wr_data}, {w[6:0], r});
    chk({no_operation_cycle, ready}, {dead, !dead});
    if (dead) begin
      instr = 14'($random(seed));
      @(negedge clk);
      chk({ready, pc}, {1'b1, e_pc});
    end
  endtask : run

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial begin
    logic [13:0] w;
    logic [7:0]  op;
    e_pc = 0;
    e_acc = 0;
    e_z = 0;
    repeat (10) @(negedge clk);
    sys_rst = 0;
    run(14'h0B85, 8'h01);
    run(14'h0B05, 8'h01);
    run(14'h0A05, 8'hFF);
    run(14'h0A85, 8'h7F);
    run(14'h2ABC, 8'h00);
    run(14'h0B85, 8'h00);
    run(14'h0B05, 8'h05);
    run(14'h0985, 8'h10);
    for (int i = 0; i < 400; i++) begin
      w = 14'($random(seed));
      op = 8'($random(seed));
      if (i % 4 == 0) w[13:8] = `SBI_OP_DEC_SKIP;
      if (i % 4 == 1) w[13:8] = `SBI_OP_INCREMENT;
      if (i % 4 == 2) w[13:11] = `SBI_OP_JUMP;
      if (i % 3 == 0) op = (i % 4 == 0) ? 8'h01 : 8'hFF;
      run(w, op);
    end
    instr_valid = 0;
    give_verdict();
  end
endmodule : tb_skip_branch_increment_exec
`default_nettype wire
